// file: verilog/limit_timer_pkg.sv
// package for the hardware limit period timer: mode codes, widths,
// reset values, pipeline depths and shared carrier structs
// assumes nothing beyond a SystemVerilog compiler
package limit_timer_pkg;

    // widths
    localparam int COUNT_W       = 8;
    localparam int MODE_W        = 5;
    localparam int POST_W        = 4;
    localparam int PRE_W         = 3;
    localparam int SRC_W         = 3;
    localparam int NUM_SRC       = 8;

    // reset values
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;

    // synchroniser depth in timer clocks before enable and trigger act
    localparam int SYNC_STAGES   = 2;

    // mode family in the upper two mode bits
    localparam logic [1:0] FAM_FREE  = 2'h0;
    localparam logic [1:0] FAM_ONE   = 2'h1;
    localparam logic [1:0] FAM_MONO  = 2'h2;

    // low three mode bits
    localparam logic [2:0] SUB_0 = 3'h0;
    localparam logic [2:0] SUB_1 = 3'h1;
    localparam logic [2:0] SUB_2 = 3'h2;
    localparam logic [2:0] SUB_3 = 3'h3;
    localparam logic [2:0] SUB_4 = 3'h4;
    localparam logic [2:0] SUB_5 = 3'h5;
    localparam logic [2:0] SUB_6 = 3'h6;
    localparam logic [2:0] SUB_7 = 3'h7;

    // software configuration carrier
    typedef struct packed {
        logic [MODE_W-1:0] limit_mode_control;
        logic [POST_W-1:0] postscale_ratio;
        logic [PRE_W-1:0]  prescale_ratio;
        logic [SRC_W-1:0]  trigger_source_select;
    } config_type;

    // software write strobes carrier
    typedef struct packed {
        logic             count_write;
        logic [7:0]       count_data;
        logic             period_write;
        logic [7:0]       period_data;
        logic             control_write;
    } write_type;

    // decoded control actions for one timer clock
    typedef enum logic [3:0] {
        ACT_HOLD  = 4'h1,
        ACT_COUNT = 4'h2,
        ACT_CLEAR = 4'h4,
        ACT_STOP  = 4'h8
    } action_type;

endpackage : limit_timer_pkg

// file: verilog/sync_two_stage.sv
// two flip-flop synchroniser for a bus of level signals
// assumes the input is asynchronous to clk_in; output is the second stage
`timescale 1ns/10ps
`default_nettype none
module sync_two_stage
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // sync_two_stage
`default_nettype wire

// file: verilog/prescale_divider.sv
// prescaler: produces a one-cycle tick every 2^ratio timer clocks
// assumes clear_in is a same-clock pulse; ratio 0 ticks every clock
`timescale 1ns/10ps
`default_nettype none
module prescale_divider
    import limit_timer_pkg::*;
(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // control
    input  wire logic             clear_in,
    input  wire logic             run_in,
    input  wire logic [PRE_W-1:0] ratio_in,
    // tick
    output var  logic             tick_out
);

    logic [6:0] div_reg;
    logic [6:0] mask;

    // mask selects how many low bits must be ones for a tick
    always_comb
    begin
        mask     = 7'(8'(8'h01 << ratio_in) - 8'h01);
        tick_out = run_in && ((div_reg & mask) == mask);
    end

    // divider restarts on clear so the first tick is a full ratio away
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            div_reg <= 7'h00;
        else if (clear_in)
            div_reg <= 7'h00;
        else if (run_in)
            div_reg <= 7'(div_reg + 7'h01);
    end

endmodule // prescale_divider
`default_nettype wire

// file: verilog/hw_limit_period_timer.sv
// 8-bit period timer with hardware limit control, postscaler and irq
// assumes write strobes are same-clock pulses; triggers are asynchronous
`timescale 1ns/10ps
`default_nettype none
module hw_limit_period_timer
    import limit_timer_pkg::*;
(
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    // software configuration and writes
    input  wire config_type         config_in,
    input  wire write_type          write_in,
    input  wire logic               enable_set_in,
    input  wire logic               enable_clear_in,
    input  wire logic               period_irq_enable_in,
    input  wire logic               debug_freeze_in,
    // candidate trigger sources
    input  wire logic [NUM_SRC-1:0] ext_trigger_in,
    // outputs
    output var  logic [7:0]         count_value_out,
    output var  logic [7:0]         period_value_out,
    output var  logic               enable_out,
    output var  logic               postscaled_pulse_out,
    output var  logic               period_match_out,
    output var  logic               irq_out
);

    // all module state
    typedef struct packed {
        logic [7:0]        count;
        logic [7:0]        period;
        logic              enable;
        logic [POST_W-1:0] post;
        logic              armed;
        logic              trig_prev;
        logic              post_pulse;
        logic              match;
        logic              irq;
        logic              halted;
    } state_type;

    state_type  state_reg;
    state_type  state_next;

    // synchronised inputs
    logic [NUM_SRC-1:0] trig_sync;
    logic               enable_sync;

    // selected trigger and its edges
    logic               trig;
    logic               rise;
    logic               fall;
    logic               edge_any;

    // per-clock decode results
    logic               tick;
    logic               ext_reset;
    logic               pre_clear;
    logic               at_match;
    logic               reserved;
    action_type         act;
    logic [1:0]         fam;
    logic [2:0]         sub;

    // reserved code check, used only to stop the count in the decode
    function automatic logic is_reserved(input logic [MODE_W-1:0] m);
        logic [1:0] f;
        logic [2:0] s;
        f = m[4:3];
        s = m[2:0];
        is_reserved = (f == 2'h3) ||
                      ((f == FAM_MONO) &&
                       ((s == SUB_0) || (s == SUB_4) || (s == SUB_5)));
    endfunction

    // codes whose match clears enable and halts the count
    function automatic logic clears_on_match(input logic [MODE_W-1:0] m);
        clears_on_match = (m[4:3] == FAM_ONE) ||
                          ((m[4:3] == FAM_MONO) && (m[2:1] == 2'h3));
    endfunction

    // triggers and enable cross into the timer clock via two flops
    sync_two_stage #(.WIDTH(NUM_SRC)) trig_sync_u
    (
        .clk_in   (clk_in),
        .resetn_in(resetn_in),
        .async_in (ext_trigger_in),
        .sync_out (trig_sync)
    );

    // enable takes the same two-flop delay as the triggers
    sync_two_stage #(.WIDTH(1)) en_sync_u
    (
        .clk_in   (clk_in),
        .resetn_in(resetn_in),
        .async_in (state_reg.enable),
        .sync_out (enable_sync)
    );

    // prescaler steps only while the decode says count
    prescale_divider pre_u
    (
        .clk_in   (clk_in),
        .resetn_in(resetn_in),
        .clear_in (pre_clear),
        .run_in   (act == ACT_COUNT),
        .ratio_in (config_in.prescale_ratio),
        .tick_out (tick)
    );

    // source select and edge detection on the synchronised trigger
    always_comb
    begin
        trig     = trig_sync[config_in.trigger_source_select];
        rise     = trig && !state_reg.trig_prev && !debug_freeze_in;
        fall     = !trig && state_reg.trig_prev && !debug_freeze_in;
        edge_any = rise || fall;
        fam      = config_in.limit_mode_control[4:3];
        sub      = config_in.limit_mode_control[2:0];
        reserved = is_reserved(config_in.limit_mode_control);
        at_match = (state_reg.count == state_reg.period);
    end

    // mode decode into one action for this clock; a frozen debug
    // state treats the trigger as inactive so it cannot gate or reset
    always_comb
    begin
        logic lvl_hi;
        logic lvl_lo;
        lvl_hi    = trig && !debug_freeze_in;
        lvl_lo    = !trig && !debug_freeze_in;
        act       = ACT_HOLD;
        ext_reset = 1'b0;
        // a halted one-shot sits out the sync delay of its own clear;
        // the two late enabled clocks would otherwise step off zero
        if (reserved)
            act = ACT_STOP;
        else if (!enable_sync || state_reg.halted)
            act = ACT_HOLD;
        else
        begin
            unique case (fam)
                FAM_FREE:
                begin
                    unique case (sub)
                        SUB_0: act = ACT_COUNT;
                        SUB_1: act = lvl_hi ? ACT_COUNT : ACT_HOLD;
                        SUB_2: act = lvl_lo ? ACT_COUNT : ACT_HOLD;
                        SUB_3: ext_reset = edge_any;
                        SUB_4: ext_reset = rise;
                        SUB_5: ext_reset = fall;
                        SUB_6: ext_reset = lvl_lo;
                        SUB_7: ext_reset = lvl_hi;
                    endcase
                    if (sub >= SUB_3)
                        act = ext_reset ? ACT_CLEAR : ACT_COUNT;
                end
                // software start runs at once, edge starts wait for arming
                FAM_ONE:
                begin
                    unique case (sub)
                        SUB_0: act = ACT_COUNT;
                        SUB_1, SUB_2, SUB_3:
                            act = state_reg.armed ? ACT_COUNT : ACT_HOLD;
                        SUB_4: ext_reset = rise && state_reg.armed;
                        SUB_5: ext_reset = fall && state_reg.armed;
                        SUB_6: ext_reset = lvl_lo;
                        SUB_7: ext_reset = lvl_hi;
                    endcase
                    if (sub >= SUB_4)
                        act = ext_reset ? ACT_CLEAR :
                              (state_reg.armed ? ACT_COUNT : ACT_HOLD);
                end
                // level one-shot clears at its reset level; edge codes arm
                FAM_MONO:
                begin
                    if (sub == SUB_6)
                        ext_reset = lvl_lo;
                    else if (sub == SUB_7)
                        ext_reset = lvl_hi;
                    if (sub >= SUB_6)
                        act = ext_reset ? ACT_CLEAR : ACT_COUNT;
                    else
                        act = state_reg.armed ? ACT_COUNT : ACT_HOLD;
                end
                default: act = ACT_STOP;
            endcase
        end
    end

    // count write, control write, reset event clear the scalers
    assign pre_clear = write_in.count_write || write_in.control_write ||
                       ext_reset;

    // next state
    always_comb
    begin
        logic start_edge;
        start_edge            = 1'b0;
        state_next            = state_reg;
        state_next.trig_prev  = trig;
        state_next.post_pulse = 1'b0;
        state_next.match      = 1'b0;
        state_next.irq        = 1'b0;

        // start edge for edge-start families
        if (fam == FAM_ONE || fam == FAM_MONO)
        begin
            unique case (sub)
                SUB_1, SUB_4, SUB_6: start_edge = rise;
                SUB_2, SUB_5, SUB_7: start_edge = fall;
                SUB_3: start_edge = edge_any;
                default: start_edge = 1'b0;
            endcase
        end
        if (!enable_sync)
            state_next.armed = 1'b0;
        else if (start_edge)
            state_next.armed = 1'b1;

        // halt ends once the cleared enable has crossed the sync
        if (!enable_sync)
            state_next.halted = 1'b0;

        // software enable; set wins over hardware clear below
        if (enable_clear_in)
            state_next.enable = 1'b0;

        // counting
        unique case (act)
            ACT_CLEAR:
                state_next.count = COUNT_RESET;
            ACT_COUNT:
            begin
                // every step of the count waits for a prescaler tick
                if (tick)
                begin
                    if (at_match)
                    begin
                        state_next.count = COUNT_RESET;
                        state_next.match = 1'b1;
                        if (state_reg.post == config_in.postscale_ratio)
                        begin
                            state_next.post       = '0;
                            state_next.post_pulse = 1'b1;
                            state_next.irq = period_irq_enable_in;
                        end
                        else
                            state_next.post = POST_W'(state_reg.post + 1'b1);
                        if (clears_on_match(config_in.limit_mode_control))
                        begin
                            state_next.enable = 1'b0;
                            state_next.armed  = 1'b0;
                            state_next.halted = 1'b1;
                        end
                        else if (fam == FAM_MONO)
                            state_next.armed = 1'b0;
                    end
                    else
                        state_next.count = 8'(state_reg.count + 8'h01);
                end
            end
            ACT_STOP:
                state_next.count = state_reg.count;
            ACT_HOLD:
                state_next.count = state_reg.count;
        endcase

        // scaler clear has the last word on the postscaler
        if (pre_clear)
            state_next.post = '0;
        if (enable_set_in)
        begin
            state_next.enable = 1'b1;
            state_next.halted = 1'b0;
        end

        // software writes override count and period
        if (write_in.count_write)
            state_next.count = write_in.count_data;
        if (write_in.period_write)
            state_next.period = write_in.period_data;
    end

    // one register for the whole state
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg            <= '0;
            state_reg.count      <= COUNT_RESET;
            state_reg.period     <= PERIOD_RESET;
        end
        else
            state_reg <= state_next;
    end

    // outputs straight from state flops
    assign count_value_out      = state_reg.count;
    assign period_value_out     = state_reg.period;
    assign enable_out           = state_reg.enable;
    assign postscaled_pulse_out = state_reg.post_pulse;
    assign period_match_out     = state_reg.match;
    assign irq_out              = state_reg.irq;

endmodule // hw_limit_period_timer
`default_nettype wire

// file: tb/limit_timer_properties.sv
// checker for the hardware limit period timer, bound to its ports
// assumes one timer clock and the active low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module limit_timer_properties
    import limit_timer_pkg::*;
(
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    // timer inputs
    input  wire config_type         config_in,
    input  wire write_type          write_in,
    input  wire logic               enable_set_in,
    input  wire logic               enable_clear_in,
    input  wire logic               period_irq_enable_in,
    input  wire logic               debug_freeze_in,
    input  wire logic [NUM_SRC-1:0] ext_trigger_in,
    // timer outputs
    input  wire logic [7:0]         count_value_out,
    input  wire logic [7:0]         period_value_out,
    input  wire logic               enable_out,
    input  wire logic               postscaled_pulse_out,
    input  wire logic               period_match_out,
    input  wire logic               irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    logic [MODE_W-1:0] mode;
    logic              reserved;
    logic [4:0]        match_cnt_reg;
    logic [2:0]        off_cnt_reg;

    // mode decode for the antecedents
    assign mode = config_in.limit_mode_control;
    assign reserved = (mode[4:3] == 2'h3) || (mode == 5'h10)
                      || (mode == 5'h14) || (mode == 5'h15);

    // matches since the last pulse; writes clear it like the postscaler
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            match_cnt_reg <= 5'h00;
        else if (postscaled_pulse_out || write_in.count_write
                 || write_in.control_write)
            match_cnt_reg <= 5'h00;
        else if (period_match_out)
            match_cnt_reg <= match_cnt_reg + 5'h01;
    end

    // saturating count of cycles with enable low, covers sync delay
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            off_cnt_reg <= 3'h0;
        else if (enable_out)
            off_cnt_reg <= 3'h0;
        else if (off_cnt_reg != 3'h7)
            off_cnt_reg <= off_cnt_reg + 3'h1;
    end

    reset_values_a: assert property ($rose(resetn_in) |->
        count_value_out == 8'h00 && period_value_out == 8'hFF)
        else $error("count or period wrong after reset");
    wrap_zero_a: assert property (period_match_out |->
        count_value_out == 8'h00
        && $past(count_value_out) == $past(period_value_out))
        else $error("match without count at period then zero");
    post_match_a: assert property (postscaled_pulse_out |->
        period_match_out) else $error("postscaled pulse without match");
    post_ratio_a: assert property (mode == 5'h00 && period_match_out |->
        postscaled_pulse_out
        == (match_cnt_reg == {1'b0, config_in.postscale_ratio}))
        else $error("postscaled pulse at wrong match count");
    irq_gate_a: assert property ($stable(period_irq_enable_in) |->
        irq_out == (postscaled_pulse_out && period_irq_enable_in))
        else $error("irq does not follow pulse and enable");
    freeze_step_a: assert property (debug_freeze_in
        && $past(debug_freeze_in) && !$past(write_in.count_write) |->
        $stable(count_value_out) || period_match_out
        || count_value_out == $past(count_value_out) + 8'h01)
        else $error("trigger acted during freeze");
    reserved_quiet_a: assert property (reserved && $past(reserved)
        && !$past(write_in.count_write) |-> $stable(count_value_out)
        && !period_match_out && !irq_out)
        else $error("reserved mode not quiet");
    count_write_a: assert property (write_in.count_write |=>
        count_value_out == $past(write_in.count_data))
        else $error("count write not taken");
    oneshot_clear_a: assert property (period_match_out
        && mode[4:3] == FAM_ONE && !enable_set_in
        && !$past(enable_set_in) |-> ##[0:1] !enable_out)
        else $error("one-shot left enable set");
    mono_keep_a: assert property (period_match_out
        && mode[4:3] == FAM_MONO && !mode[2] && $past(enable_out)
        && !$past(enable_clear_in) |-> enable_out ##1
        count_value_out == 8'h00) else $error("monostable stop wrong");
    gate_hold_a: assert property (mode == 5'h00 && off_cnt_reg == 3'h7
        && !$past(write_in.count_write) |-> $stable(count_value_out))
        else $error("count moved while disabled");

    // main scenarios reached
    post_div_c: cover property (postscaled_pulse_out
        && config_in.postscale_ratio != 4'h0);
    oneshot_c: cover property (mode[4:3] == FAM_ONE && $fell(enable_out));
    irq_c: cover property (irq_out);
endmodule // limit_timer_properties

bind hw_limit_period_timer limit_timer_properties CHK
(
    .clk_in, .resetn_in, .config_in, .write_in, .enable_set_in,
    .enable_clear_in, .period_irq_enable_in, .debug_freeze_in,
    .ext_trigger_in, .count_value_out, .period_value_out, .enable_out,
    .postscaled_pulse_out, .period_match_out, .irq_out
);
`default_nettype wire

// file: tb/trigger_source_model.sv
// model of the on-chip logic that drives the timer trigger sources
// assumes select_in is the timer's own source selection
`timescale 1ns/10ps
`default_nettype none
module trigger_source_model
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    // requested level of the selected source
    input  wire logic [2:0] select_in,
    input  wire logic       level_in,
    // trigger sources
    output var  logic [7:0] trig_out
);
    logic [3:0] gap_reg;
    logic       lvl_reg;
    logic       tog_reg;

    // a change is deferred until seven clocks after the last one, which
    // also keeps every level for more than three clocks
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gap_reg <= 4'h0;
            lvl_reg <= 1'b0;
            tog_reg <= 1'b0;
        end
        else
        begin
            tog_reg <= ~tog_reg;
            if (level_in != lvl_reg && gap_reg >= 4'h6)
            begin
                gap_reg <= 4'h0;
                lvl_reg <= level_in;
            end
            else if (gap_reg != 4'hF)
                gap_reg <= gap_reg + 4'h1;
        end
    end

    // unselected lines toggle each clock so a wrong pick shows at once
    always_comb
    begin
        trig_out = {8{tog_reg}};
        trig_out[select_in] = lvl_reg;
    end
endmodule // trigger_source_model
`default_nettype wire

// file: tb/hw_limit_period_timer_tb.sv
// testbench for the hardware limit period timer with a reference model
// assumes the timer, its package and the trigger source model
`timescale 1ns/10ps
`default_nettype none
module hw_limit_period_timer_tb
    import limit_timer_pkg::*;
;
    logic               clk_in, resetn_in;
    config_type         cfg;
    write_type          wr;
    logic               en_set, en_clr, irq_en, freeze, trig_lvl, seen;
    logic [NUM_SRC-1:0] trig;
    logic [7:0]         cnt, per;
    logic               en, post, match, irq;
    logic [4:0]         rsv [5] = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1F};
    int                 bad_count, cmp_count, i;

    // timer under test
    hw_limit_period_timer DUT
    (
        .clk_in               (clk_in),
        .resetn_in            (resetn_in),
        .config_in            (cfg),
        .write_in             (wr),
        .enable_set_in        (en_set),
        .enable_clear_in      (en_clr),
        .period_irq_enable_in (irq_en),
        .debug_freeze_in      (freeze),
        .ext_trigger_in       (trig),
        .count_value_out      (cnt),
        .period_value_out     (per),
        .enable_out           (en),
        .postscaled_pulse_out (post),
        .period_match_out     (match),
        .irq_out              (irq)
    );

    // logic behind the trigger sources
    trigger_source_model SRC
    (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .select_in (cfg.trigger_source_select),
        .level_in  (trig_lvl),
        .trig_out  (trig)
    );

    // 25 MHz timer clock
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cmp1(input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // stop, let the sync drain, load count, period and mode, then start
    task automatic setup(input logic [4:0] md, input logic [7:0] c,
                         input logic [7:0] p);
        en_clr = 1'b1;
        tick(1);
        en_clr = 1'b0;
        tick(5);
        cfg.limit_mode_control = md;
        wr = '{1'b1, c, 1'b1, p, 1'b1};
        tick(1);
        wr = '0;
        tick(2);
        en_set = 1'b1;
        tick(1);
        en_set = 1'b0;
    endtask

    // software gate run checked cycle by cycle against an integer model
    task automatic run_model(input int p, input int r, input logic ie);
        int   m, pm, k;
        logic mt, pp;
        m = 1;
        pm = 0;
        mt = 1'b0;
        pp = 1'b0;
        cfg.postscale_ratio = 4'(r);
        irq_en = ie;
        setup(5'h00, 8'h00, 8'(p));
        for (k = 0; k < 20 && cnt !== 8'h01; k++)
            tick(1);
        for (k = 0; k < (p + 1) * (r + 1) * 2 + 4; k++)
        begin
            cmp8(8'(m), cnt);
            cmp1(mt, match);
            cmp1(pp, post);
            cmp1(pp & ie, irq);
            wr.control_write = (k == p + 3);
            mt = (m == p);
            pp = mt && (pm == r);
            if (mt)
                pm = pp ? 0 : pm + 1;
            if (k == p + 3)
                pm = 0;
            m = mt ? 0 : m + 1;
            tick(1);
        end
        wr = '0;
    endtask

    // main sequence
    initial
    begin
        resetn_in = 1'b0;
        cfg = '0;
        wr = '0;
        {en_set, en_clr, irq_en, freeze, trig_lvl} = 5'h00;
        bad_count = 0;
        cmp_count = 0;
        void'($urandom(32'h1BCA3F9C));
        tick(8);
        resetn_in = 1'b1;
        tick(1);
        cmp8(8'h00, cnt);
        cmp8(8'hFF, per);
        for (i = 0; i < 3; i++)
            run_model(4 + $urandom % 20, $urandom % 4, i != 1);
        // disabled count holds a written value
        en_clr = 1'b1;
        tick(1);
        en_clr = 1'b0;
        tick(6);
        wr = '{1'b1, 8'h40, 1'b0, 8'h00, 1'b0};
        tick(1);
        wr = '0;
        tick(6);
        cmp8(8'h40, cnt);
        // rising edge reset on a random source, then frozen
        cfg.trigger_source_select = 3'($urandom % 8);
        setup(5'h04, 8'h00, 8'hFF);
        tick(30);
        cmp1(1'b1, cnt > 8'h14);
        trig_lvl = 1'b1;
        seen = 1'b0;
        for (i = 0; i < 12; i++)
        begin
            seen |= (cnt < 8'h03);
            tick(1);
        end
        cmp1(1'b1, seen);
        freeze = 1'b1;
        trig_lvl = 1'b0;
        tick(8);
        trig_lvl = 1'b1;
        tick(10);
        cmp1(1'b1, cnt > 8'h0F);
        freeze = 1'b0;
        // software start one-shot
        trig_lvl = 1'b0;
        setup(5'h08, 8'h00, 8'h0A);
        for (i = 0; i < 40 && en !== 1'b0; i++)
            tick(1);
        cmp1(1'b0, en);
        tick(4);
        cmp8(8'h00, cnt);
        // rising edge monostable
        setup(5'h11, 8'h00, 8'h06);
        tick(10);
        cmp8(8'h00, cnt);
        trig_lvl = 1'b1;
        for (i = 0; i < 30 && match !== 1'b1; i++)
            tick(1);
        tick(4);
        cmp1(1'b1, en);
        cmp8(8'h00, cnt);
        // low level reset
        trig_lvl = 1'b0;
        setup(5'h06, 8'h20, 8'hFF);
        tick(8);
        cmp8(8'h00, cnt);
        trig_lvl = 1'b1;
        tick(8);
        cmp1(1'b1, cnt != 8'h00);
        // level one-shot halts at zero and clears enable
        setup(5'h16, 8'h00, 8'h08);
        for (i = 0; i < 30 && en !== 1'b0; i++)
            tick(1);
        tick(4);
        cmp1(1'b0, en);
        cmp8(8'h00, cnt);
        // reserved codes keep the count still
        for (i = 0; i < 5; i++)
        begin
            setup(rsv[i], 8'h33, 8'h35);
            tick(8);
            cmp8(8'h33, cnt);
        end
        stop_test();
    end

    // the run needs under 1000 clocks; 10000 means a hang
    initial
    begin
        #400000;
        bad_count++;
        stop_test();
    end
endmodule // hw_limit_period_timer_tb
`default_nettype wire
